//--- hw/rsld_pkg.sv
package rsld_pkg;

  // pull class reported by the analog sensing stage for a three-level strap
  typedef enum logic [1:0] {
    RSLD_PULL_NONE = 2'h0,
    RSLD_PULL_UP   = 2'h1,
    RSLD_PULL_DOWN = 2'h2
  } rsld_pull_t;

  // resistor class reported for a five-level strap
  typedef enum logic [2:0] {
    RSLD_CLS_200K_DN = 3'h0,
    RSLD_CLS_200K_UP = 3'h1,
    RSLD_CLS_10K_DN  = 3'h2,
    RSLD_CLS_10K_UP  = 3'h3,
    RSLD_CLS_10R_DN  = 3'h4
  } rsld_cls_t;

  // configuration stage entered once the straps are resolved
  typedef enum logic [1:0] {
    RSLD_STAGE_NONE    = 2'h0,
    RSLD_STAGE_SOC_CFG = 2'h1,
    RSLD_STAGE_OTP_CFG = 2'h2
  } rsld_stage_t;

  localparam int unsigned RSLD_NPORTS = 4;

  // raw strap bundle as sensed at the pins
  typedef struct packed {
    rsld_pull_t                 dout_pull;
    rsld_pull_t                 clk_pull;
    rsld_cls_t                  fixed_cls;
    rsld_cls_t                  charge_cls;
    logic [RSLD_NPORTS-1:0]     dplus_off;
    logic [RSLD_NPORTS-1:0]     dminus_off;
  } rsld_strap_t;

  // decoded settings handed to the hub core
  typedef struct packed {
    logic                       smbus_mode;
    logic [RSLD_NPORTS-1:0]     fixed_mask;
    logic [RSLD_NPORTS-1:0]     charge_mask;
    logic [RSLD_NPORTS-1:0]     usb2_off;
    logic [RSLD_NPORTS-1:0]     ss_off;
  } rsld_cfg_t;

  localparam int unsigned RSLD_STRAP_W = $bits(rsld_strap_t);

  // shared serial pin positions on the pin vectors
  localparam int unsigned RSLD_PIN_CE  = 3;
  localparam int unsigned RSLD_PIN_DIN = 2;
  localparam int unsigned RSLD_PIN_DO  = 1;
  localparam int unsigned RSLD_PIN_CLK = 0;

  // cycles after reset release before the synchronised straps are trusted
  localparam logic [1:0]  RSLD_SETTLE_CYC = 2'h3;

  // values after reset
  localparam rsld_strap_t RSLD_STRAP_RST  = '0;
  localparam rsld_cfg_t   RSLD_CFG_RST    = '0;
  localparam logic [3:0]  RSLD_PIN_OUT_RST  = 4'h0;
  localparam logic [3:0]  RSLD_PIN_OEN_RST  = 4'hF;

endpackage

//--- hw/rsld_sync.sv
`timescale 1ns/1ps
module rsld_sync
  import rsld_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // two stages; the first is read only by the second
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

//--- hw/rsld_top.sv
`timescale 1ns/1ps
// What this block does
// - capture all straps once at reset release
// - hand strap pins to run-time functions afterwards
// - pull-ups on data-out and clock select management
// - no pulls on both pins select serial master
// - pin roles follow the selected mode
// - check firmware signature before using external memory
// - off strap 0 enables, 1 disables line
// - port off only when both straps high
// - disabled usb2 port also disables superspeed twin
// - decode five-level fixed port strap to mask in management mode
// - decode five-level charge port strap to mask in management mode
// - management mode goes host config, else otp
module rsld_top
  import rsld_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // strap class codes from the analog sensing stage
  input  wire rsld_pull_t             i_dout_pull,
  input  wire rsld_pull_t             i_clk_pull,
  input  wire rsld_cls_t              i_fixed_port_strap,
  input  wire rsld_cls_t              i_charge_port_strap,
  input  wire logic [RSLD_NPORTS-1:0] i_port_dplus_off_strap,
  input  wire logic [RSLD_NPORTS-1:0] i_port_dminus_off_strap,
  // shared serial pins, index 3 down to 0
  input  wire logic [3:0]             i_pin_in,
  output logic      [3:0]             o_pin_out,
  output logic      [3:0]             o_pin_oe_n,
  // serial master side of the core
  input  wire logic                   i_spi_ce_n,
  input  wire logic                   i_spi_dout,
  input  wire logic                   i_spi_clk,
  output logic                        o_serial_in_pin,
  // management slave side of the core
  input  wire logic                   i_mgmt_data_low,
  input  wire logic                   i_mgmt_clock_low,
  output logic                        o_mgmt_data_pin,
  output logic                        o_mgmt_clock_pin,
  // signature check handshake with the core
  input  wire logic                   i_sig_done,
  input  wire logic                   i_sig_ok,
  output logic                        o_sig_check_req,
  output logic                        o_ext_rom_en,
  // resolved configuration
  output rsld_cfg_t                   o_cfg,
  output logic                        o_cfg_valid,
  output rsld_stage_t                 o_stage,
  output logic                        o_strap_odd
);

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_CAPTURE,
    ST_SIG_WAIT,
    ST_DONE
  } rsld_state_t;

  rsld_strap_t strap_raw;
  rsld_strap_t strap_s;
  logic [3:0]  pin_s;

  // straps and pins come from outside the clock domain
  assign strap_raw = '{dout_pull:  i_dout_pull,
                       clk_pull:   i_clk_pull,
                       fixed_cls:  i_fixed_port_strap,
                       charge_cls: i_charge_port_strap,
                       dplus_off:  i_port_dplus_off_strap,
                       dminus_off: i_port_dminus_off_strap};

  rsld_sync #(
    .W (RSLD_STRAP_W)
  ) u_strap_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     (strap_raw),
    .o_q     (strap_s)
  );

  rsld_sync #(
    .W (4)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     (i_pin_in),
    .o_q     (pin_s)
  );

  // level count of a five-level class; unknown codes count as none
  function automatic logic [2:0] rsld_level(input rsld_cls_t cls);
    logic [2:0] lvl;
    lvl = 3'h0;
    case (cls)
      RSLD_CLS_200K_DN: lvl = 3'h0;
      RSLD_CLS_200K_UP: lvl = 3'h1;
      RSLD_CLS_10K_DN:  lvl = 3'h2;
      RSLD_CLS_10K_UP:  lvl = 3'h3;
      RSLD_CLS_10R_DN:  lvl = 3'h4;
      default:          lvl = 3'h0;
    endcase
    return lvl;
  endfunction

  // decode of the synchronised straps, purely combinational
  rsld_strap_t            strap_q;
  logic                   mode_smbus;
  logic                   mode_odd;
  logic [2:0]             fixed_lvl;
  logic [2:0]             charge_lvl;
  logic [RSLD_NPORTS-1:0] fixed_dec;
  logic [RSLD_NPORTS-1:0] charge_dec;
  logic [RSLD_NPORTS-1:0] port_off;

  // mixed pull patterns fall back to the serial master mode
  assign mode_smbus = (strap_s.dout_pull == RSLD_PULL_UP) &&
                      (strap_s.clk_pull == RSLD_PULL_UP);
  assign mode_odd   = !mode_smbus &&
                      !((strap_s.dout_pull == RSLD_PULL_NONE) &&
                        (strap_s.clk_pull == RSLD_PULL_NONE));
  assign fixed_lvl  = rsld_level(strap_s.fixed_cls);
  assign charge_lvl = rsld_level(strap_s.charge_cls);

  // per port: level masks grow from port 1; off needs both lines off
  for (genvar p = 0; p < RSLD_NPORTS; p++) begin : g_port
    assign fixed_dec[p]  = (fixed_lvl  > 3'(p));
    assign charge_dec[p] = (charge_lvl > 3'(p));
    assign port_off[p]   = strap_s.dplus_off[p] &
                           strap_s.dminus_off[p];
  end

  // sequencing and capture state
  rsld_state_t state_q;
  rsld_state_t state_d;
  logic [1:0]  settle_q;
  logic [1:0]  settle_d;
  rsld_cfg_t   cfg_q;
  rsld_cfg_t   cfg_d;
  rsld_strap_t strap_d;
  logic        valid_q;
  logic        valid_d;
  rsld_stage_t stage_q;
  rsld_stage_t stage_d;
  logic        sig_req_q;
  logic        sig_req_d;
  logic        rom_en_q;
  logic        rom_en_d;
  logic        odd_q;
  logic        odd_d;

  // capture happens in exactly one state, so values hold until reset
  always_comb begin
    state_d   = state_q;
    settle_d  = settle_q;
    cfg_d     = cfg_q;
    strap_d   = strap_q;
    valid_d   = valid_q;
    stage_d   = stage_q;
    sig_req_d = sig_req_q;
    rom_en_d  = rom_en_q;
    odd_d     = odd_q;
    case (state_q)
      ST_HOLD: begin
        settle_d = 2'h0;
        state_d  = ST_SETTLE;
      end
      // let the synchronisers fill with post-release strap levels
      ST_SETTLE: begin
        settle_d = settle_q + 2'h1;
        if (settle_q == RSLD_SETTLE_CYC - 2'h1) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        strap_d           = strap_s;
        odd_d             = mode_odd;
        cfg_d.smbus_mode  = mode_smbus;
        // the level straps only exist on the pins in management mode
        cfg_d.fixed_mask  = mode_smbus ? fixed_dec  : '0;
        cfg_d.charge_mask = mode_smbus ? charge_dec : '0;
        cfg_d.usb2_off    = port_off;
        cfg_d.ss_off      = port_off;
        if (mode_smbus) begin
          stage_d = RSLD_STAGE_SOC_CFG;
          valid_d = 1'b1;
          state_d = ST_DONE;
        end else begin
          sig_req_d = 1'b1;
          state_d   = ST_SIG_WAIT;
        end
      end
      // external memory stays unused until the core confirms the signature
      ST_SIG_WAIT: begin
        if (i_sig_done) begin
          sig_req_d = 1'b0;
          rom_en_d  = i_sig_ok;
          stage_d   = RSLD_STAGE_OTP_CFG;
          valid_d   = 1'b1;
          state_d   = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q   <= ST_HOLD;
      settle_q  <= 2'h0;
      cfg_q     <= RSLD_CFG_RST;
      strap_q   <= RSLD_STRAP_RST;
      valid_q   <= 1'b0;
      stage_q   <= RSLD_STAGE_NONE;
      sig_req_q <= 1'b0;
      rom_en_q  <= 1'b0;
      odd_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      settle_q  <= settle_d;
      cfg_q     <= cfg_d;
      strap_q   <= strap_d;
      valid_q   <= valid_d;
      stage_q   <= stage_d;
      sig_req_q <= sig_req_d;
      rom_en_q  <= rom_en_d;
      odd_q     <= odd_d;
    end
  end

  // pin handover state
  logic       handed;
  logic [3:0] pin_out_q;
  logic [3:0] pin_out_d;
  logic [3:0] pin_oen_q;
  logic [3:0] pin_oen_d;
  logic       sin_q;
  logic       sin_d;
  logic       mdat_q;
  logic       mdat_d;
  logic       mclk_q;
  logic       mclk_d;

  // pins stay released while straps are sensed
  assign handed = (state_q == ST_SIG_WAIT) || (state_q == ST_DONE);

  // one cycle of output latency; fine at serial rom and bus rates
  always_comb begin
    pin_out_d = RSLD_PIN_OUT_RST;
    pin_oen_d = RSLD_PIN_OEN_RST;
    sin_d     = 1'b0;
    mdat_d    = 1'b1;
    mclk_d    = 1'b1;
    if (handed && cfg_q.smbus_mode) begin
      // open drain: only ever drive low, level straps stay inputs
      pin_out_d[RSLD_PIN_DO]  = 1'b0;
      pin_oen_d[RSLD_PIN_DO]  = !i_mgmt_data_low;
      pin_out_d[RSLD_PIN_CLK] = 1'b0;
      pin_oen_d[RSLD_PIN_CLK] = !i_mgmt_clock_low;
      mdat_d                  = pin_s[RSLD_PIN_DO];
      mclk_d                  = pin_s[RSLD_PIN_CLK];
    end else if (handed) begin
      pin_out_d[RSLD_PIN_CE]  = i_spi_ce_n;
      pin_oen_d[RSLD_PIN_CE]  = 1'b0;
      pin_out_d[RSLD_PIN_DO]  = i_spi_dout;
      pin_oen_d[RSLD_PIN_DO]  = 1'b0;
      pin_out_d[RSLD_PIN_CLK] = i_spi_clk;
      pin_oen_d[RSLD_PIN_CLK] = 1'b0;
      sin_d                   = pin_s[RSLD_PIN_DIN];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pin_out_q <= RSLD_PIN_OUT_RST;
      pin_oen_q <= RSLD_PIN_OEN_RST;
      sin_q     <= 1'b0;
      mdat_q    <= 1'b1;
      mclk_q    <= 1'b1;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oen_q <= pin_oen_d;
      sin_q     <= sin_d;
      mdat_q    <= mdat_d;
      mclk_q    <= mclk_d;
    end
  end

  // all outputs straight from flops
  assign o_pin_out        = pin_out_q;
  assign o_pin_oe_n       = pin_oen_q;
  assign o_serial_in_pin  = sin_q;
  assign o_mgmt_data_pin  = mdat_q;
  assign o_mgmt_clock_pin = mclk_q;
  assign o_sig_check_req  = sig_req_q;
  assign o_ext_rom_en     = rom_en_q;
  assign o_cfg            = cfg_q;
  assign o_cfg_valid      = valid_q;
  assign o_stage          = stage_q;
  assign o_strap_odd      = odd_q;

endmodule

//--- tb/rsld_top_properties.sv
`timescale 1ns/1ps
module rsld_top_properties
  import rsld_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_spi_ce_n,
  input wire logic       i_spi_dout,
  input wire logic       i_spi_clk,
  input wire logic       i_mgmt_data_low,
  input wire logic       i_mgmt_clock_low,
  input wire logic       i_sig_done,
  input wire logic       i_sig_ok,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe_n,
  input wire logic       o_sig_check_req,
  input wire logic       o_ext_rom_en,
  input wire rsld_cfg_t  o_cfg,
  input wire logic       o_cfg_valid,
  input wire rsld_stage_t o_stage
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // release, settle and capture, then the answer
  sequence rel_s; $rose(i_rst_n); endsequence
  // release edge plus three settle edges plus the capture edge stay quiet
  sequence quiet_s; !(o_cfg_valid || o_sig_check_req) [*5]; endsequence
  sequence up_s; o_cfg_valid || o_sig_check_req; endsequence
  capture_delay_a: assert property (rel_s |-> quiet_s ##1 up_s)
    else $error("resolve timing wrong");
  cfg_hold_a: assert property (o_cfg_valid |=> o_cfg_valid && $stable(o_cfg))
    else $error("cfg changed after capture");
  pair_off_a: assert property (o_cfg.ss_off == o_cfg.usb2_off)
    else $error("superspeed twin differs");
  mask_shape_a: assert property (o_cfg.fixed_mask inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF} &&
    o_cfg.charge_mask inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}) else $error("mask not a level");
  stage_pick_a: assert property (o_cfg_valid |->
    o_stage == (o_cfg.smbus_mode ? RSLD_STAGE_SOC_CFG : RSLD_STAGE_OTP_CFG)) else $error("bad stage");
  spi_mask_a: assert property (o_sig_check_req |->
    !o_cfg.smbus_mode && o_cfg.fixed_mask == 4'h0 && o_cfg.charge_mask == 4'h0) else $error("spi masks");
  sig_result_a: assert property (o_sig_check_req && i_sig_done |=>
    !o_sig_check_req && o_cfg_valid && o_ext_rom_en == $past(i_sig_ok)) else $error("sig result");
  rom_gate_a: assert property (o_ext_rom_en |-> !o_cfg.smbus_mode && o_cfg_valid)
    else $error("rom enabled without signature");
  // handover lags the state by one register
  smb_pins_a: assert property (o_cfg_valid && $past(o_cfg_valid) && o_cfg.smbus_mode |->
    o_pin_out[1:0] == 2'h0 && o_pin_oe_n == {2'h3, ~$past(i_mgmt_data_low), ~$past(i_mgmt_clock_low)})
    else $error("mgmt pin drive");
  spi_pins_a: assert property (o_sig_check_req && $past(o_sig_check_req) |->
    o_pin_oe_n == 4'h4 && o_pin_out[3] == $past(i_spi_ce_n) &&
    o_pin_out[1:0] == {$past(i_spi_dout), $past(i_spi_clk)}) else $error("spi pin drive");
endmodule

bind rsld_top rsld_top_properties u_rsld_top_properties (.i_mclk, .i_rst_n, .i_spi_ce_n, .i_spi_dout,
  .i_spi_clk, .i_mgmt_data_low, .i_mgmt_clock_low, .i_sig_done, .i_sig_ok, .o_pin_out, .o_pin_oe_n,
  .o_sig_check_req, .o_ext_rom_en, .o_cfg, .o_cfg_valid, .o_stage);

//--- tb/rsld_board.sv
`timescale 1ns/1ps
module rsld_board
  import rsld_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire rsld_strap_t i_strap,
  input  wire logic        i_rom_di,
  input  wire logic [3:0]  i_pin_out,
  input  wire logic [3:0]  i_pin_oe_n,
  output rsld_strap_t      o_strap,
  output logic [3:0]       o_pin_lvl
);
  logic       smb;
  logic [3:0] tgl_q = 4'h5;
  // strap resistors, set while reset is held and changed once more after capture
  assign o_strap = i_strap;
  assign smb = i_strap.dout_pull == RSLD_PULL_UP && i_strap.clk_pull == RSLD_PULL_UP;
  // floating pins wander so a stale level cannot pass
  always @(posedge i_mclk) tgl_q <= ~tgl_q;
  // pull-ups in management mode, rom drives data-in otherwise
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pin_lvl[i] = smb ? 1'b1 : (i == 2 ? i_rom_di : tgl_q[i]);
      if (!i_pin_oe_n[i]) begin
        o_pin_lvl[i] = i_pin_out[i];
      end
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rsld_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  rsld_strap_t strap = '0;
  rsld_strap_t st;
  logic [3:0]  lvl, pout, poe_n;
  logic        rom_di = 1'b0, ce_n = 1'b1, sdo = 1'b0, sclk = 1'b0, sin, mdl = 1'b0, mcl = 1'b0;
  logic        mdp, mcp, sdone = 1'b0, sok = 1'b0, req, rom_en, valid, odd;
  rsld_cfg_t   cfg;
  rsld_stage_t stage;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // 20 MHz clock
  always #25 i_mclk = ~i_mclk;
  rsld_top u_rsld_top (.i_mclk, .i_rst_n, .i_dout_pull(st.dout_pull), .i_clk_pull(st.clk_pull),
    .i_fixed_port_strap(st.fixed_cls), .i_charge_port_strap(st.charge_cls),
    .i_port_dplus_off_strap(st.dplus_off), .i_port_dminus_off_strap(st.dminus_off), .i_pin_in(lvl),
    .o_pin_out(pout), .o_pin_oe_n(poe_n), .i_spi_ce_n(ce_n), .i_spi_dout(sdo), .i_spi_clk(sclk),
    .o_serial_in_pin(sin), .i_mgmt_data_low(mdl), .i_mgmt_clock_low(mcl), .o_mgmt_data_pin(mdp),
    .o_mgmt_clock_pin(mcp), .i_sig_done(sdone), .i_sig_ok(sok), .o_sig_check_req(req),
    .o_ext_rom_en(rom_en), .o_cfg(cfg), .o_cfg_valid(valid), .o_stage(stage), .o_strap_odd(odd));
  rsld_board u_rsld_board (.i_mclk, .i_strap(strap), .i_rom_di(rom_di), .i_pin_out(pout),
    .i_pin_oe_n(poe_n), .o_strap(st), .o_pin_lvl(lvl));
  task stop_test;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // wide enough for the config word plus flag bits, so nothing is cut off
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] msk(input int k);
    return 4'hF >> (4 - k);
  endfunction
  // straps set under reset, then wait for the answer
  task run(input rsld_pull_t dp, cp, input logic [2:0] f, c, input logic [3:0] pp, pm);
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    strap = {dp, cp, f, c, pp, pm};
    repeat (4) @(negedge i_mclk);
    chk({poe_n, valid, mdp, stage}, {4'hF, 1'b0, 1'b1, RSLD_STAGE_NONE});
    i_rst_n = 1'b1;
    for (int n = 0; n < 20 && valid !== 1'b1 && req !== 1'b1; n++) @(negedge i_mclk);
  endtask
  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    logic [3:0] x;
    for (int k = 0; k < 5; k++) begin
      x = (4'hA ^ 4'(k)) & (4'h6 ^ 4'(k));
      run(RSLD_PULL_UP, RSLD_PULL_UP, 3'(k), 3'(4 - k), 4'hA ^ 4'(k), 4'h6 ^ 4'(k));
      chk(cfg, {1'b1, msk(k), msk(4 - k), x, x});
      chk({stage, valid, req}, {RSLD_STAGE_SOC_CFG, 2'h2});
    end
    // late strap changes must not reach the captured set
    strap.dplus_off = 4'h0;
    strap.fixed_cls = RSLD_CLS_200K_DN;
    mdl = 1'b1;
    repeat (6) @(negedge i_mclk);
    chk(cfg, {1'b1, 4'hF, 4'h0, 4'h2, 4'h2});
    chk({poe_n, pout[1:0], mdp, mcp}, {4'hD, 2'h0, 2'h1});
    mdl = 1'b0;
    run(RSLD_PULL_NONE, RSLD_PULL_NONE, 3'h4, 3'h4, 4'hF, 4'hF);
    chk(cfg, {1'b0, 8'h00, 4'hF, 4'hF});
    chk({stage, valid, req, rom_en}, {RSLD_STAGE_NONE, 3'h2});
    sclk = 1'b1;
    ce_n = 1'b0;
    rom_di = 1'b1;
    repeat (5) @(negedge i_mclk);
    chk({poe_n, pout[3], pout[1:0], sin}, {4'h4, 1'b0, 2'h1, 1'b1});
    sdone = 1'b1;
    sok = 1'b1;
    @(negedge i_mclk);
    sdone = 1'b0;
    @(negedge i_mclk);
    chk({stage, valid, req, rom_en}, {RSLD_STAGE_OTP_CFG, 3'h5});
    // mixed pulls fall back to serial master, then signature fails
    run(RSLD_PULL_UP, RSLD_PULL_NONE, 3'h2, 3'h2, 4'h1, 4'h0);
    chk({cfg, odd, req}, {17'h0, 2'h3});
    sdone = 1'b1;
    sok = 1'b0;
    @(negedge i_mclk);
    sdone = 1'b0;
    @(negedge i_mclk);
    chk({stage, valid, req, rom_en}, {RSLD_STAGE_OTP_CFG, 3'h4});
    stop_test();
  end
endmodule
